// File: verilog/add_exec_cfg.svh
// Constants for the addition execute block: register offsets, fields,
// opcodes, address split points and reset values.
// Assumes byte addressing on an APB bus with 32-bit data.
`ifndef ADD_EXEC_CFG_SVH
`define ADD_EXEC_CFG_SVH

`define OFS_INSTR 8'h00
`define OFS_WORK 8'h04
`define OFS_BANK 8'h08
`define OFS_INDEX 8'h0C
`define OFS_CTRL 8'h10
`define OFS_FLAGS 8'h14
`define OFS_STATE 8'h18
`define OFS_MEM_ADDR 8'h1C
`define OFS_MEM_DATA 8'h20

`define OPC_ADDI 8'h0F
`define OPC_ADDR 6'h09
`define D_BIT 9
`define A_BIT 8

`define ACC_SPLIT 8'h60
`define ILO_MAX 8'h5F
`define ACC_LO_BANK 4'h0
`define ACC_HI_BANK 4'hF

`define FLG_C 0
`define FLG_DIGIT_CARRY 1
`define FLG_Z 2
`define FLG_OVERFLOW 3
`define FLG_N 4

`define RST_INSTR 16'h0000
`define RST_WORK 8'h00
`define RST_BANK 4'h0
`define RST_INDEX 12'h000
`define RST_FLAGS 5'h00
`define RST_MEM_ADDR 12'h000

`endif

// File: verilog/add_exec_pkg.sv
// Types shared by the addition execute block.
// Assumes the constants header is included where offsets are needed.
package add_exec_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DECODE = 3'b001,
      ST_READ = 3'b010,
      ST_PROC = 3'b011,
      ST_WRITE = 3'b100
   } phase_t;

   typedef struct packed {
      logic is_imm;
      logic is_reg;
      logic to_file;
      logic banked;
      logic [7:0] fld;
   } decoded_t;

   // Flag order matches the flag register bits, carry in bit 0
   typedef struct packed {
      logic [7:0] sum;
      logic neg;
      logic overflow_flag;
      logic zero;
      logic digit_carry_flag;
      logic carry;
   } add_result_t;

endpackage

// File: verilog/add_exec_adder.sv
// Eight-bit adder with the five arithmetic status flags.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module add_exec_adder (
   input wire logic [7:0] lhs,
   input wire logic [7:0] rhs,
   output add_exec_pkg::add_result_t res
);
   logic [8:0] wide;
   logic [4:0] low;

   always_comb begin
      wide = {1'b0, lhs} + {1'b0, rhs};
      low = {1'b0, lhs[3:0]} + {1'b0, rhs[3:0]};
      res.sum = wide[7:0];
      res.carry = wide[8];
      res.digit_carry_flag = low[4];
      res.zero = (wide[7:0] == 8'h00);
      res.neg = wide[7];
      res.overflow_flag = (lhs[7] == rhs[7]) && (wide[7] != lhs[7]);
   end
endmodule

// File: verilog/add_exec_ram.sv
// Data memory of 16 banks of 256 bytes, one port, registered read data.
// Read data follow the address given one edge earlier.
`timescale 1ns/10ps
module add_exec_ram (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [11:0] addr,
   input wire logic we,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] cells [0:4095];

   always_ff @(posedge ref_clk) begin
      if (we) begin
         cells[addr] <= wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 8'h00;
      end else begin
         rdata <= cells[addr];
      end
   end
endmodule

// File: verilog/add_exec_core.sv
// Execute unit for the two byte additions, with an APB register slave.
// Assumes an APB master on ref_clk; every transfer has at least one wait state, more while an instruction runs.
// How it works
// RL1: Upper byte 0000 1111 adds the literal low byte into the working register.
// RL2: Upper bits 0010 01 add a data memory byte to the working register.
// RL3: Destination bit 0 writes the sum to the working register only.
// RL4: Destination bit 1 writes the sum back to the addressed memory byte.
// RL5: Bank bit 0 resolves the address inside the access bank.
// RL6: Bank bit 1 takes the upper address bits from the bank select register.
// RL7: Extended mode, bank bit 0, address up to 5F uses indexed offset.
// RL8: Every addition updates carry, digit carry, zero, overflow and negative.
// RL9: One word, four phases: decode, read operand, process, write destination.
`timescale 1ns/10ps
`include "add_exec_cfg.svh"
module add_exec_core (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   add_exec_pkg::phase_t phase;
   add_exec_pkg::phase_t next_phase;
   add_exec_pkg::decoded_t dec;
   add_exec_pkg::add_result_t add_out;
   add_exec_pkg::add_result_t result;
   add_exec_pkg::add_result_t next_result;
   logic [15:0] instr;
   logic [15:0] next_instr;
   logic [7:0] working_reg_alias;
   logic [7:0] next_working;
   logic [3:0] bank_select_register;
   logic [3:0] next_bank;
   logic [11:0] index_base;
   logic [11:0] next_index;
   logic ext_enable;
   logic next_ext;
   logic [4:0] flags;
   logic [4:0] next_flags;
   logic illegal;
   logic next_illegal;
   logic [11:0] mem_addr;
   logic [11:0] next_mem_addr;
   logic wait_done;
   logic next_wait_done;
   logic [31:0] next_prdata;
   logic [31:0] read_mux;
   logic hit;
   logic busy;
   logic bus_write;
   logic [11:0] eff_addr;
   logic [7:0] add_rhs;
   logic [11:0] ram_addr;
   logic ram_we;
   logic [7:0] ram_wdata;
   logic [7:0] ram_rdata;

   // Instruction fields
   always_comb begin
      dec.is_imm = (instr[15:8] == `OPC_ADDI); // [RL1]
      dec.is_reg = (instr[15:10] == `OPC_ADDR); // [RL2]
      dec.to_file = instr[`D_BIT];
      dec.banked = instr[`A_BIT];
      dec.fld = instr[7:0];
   end

   // Operand address
   always_comb begin
      if (dec.banked) begin
         eff_addr = {bank_select_register, dec.fld}; // [RL6]
      end else if (ext_enable && dec.fld <= `ILO_MAX) begin
         eff_addr = 12'(index_base + {4'h0, dec.fld}); // [RL7]
      end else if (dec.fld < `ACC_SPLIT) begin
         eff_addr = {`ACC_LO_BANK, dec.fld}; // [RL5]
      end else begin
         eff_addr = {`ACC_HI_BANK, dec.fld}; // [RL5]
      end
   end

   assign add_rhs = dec.is_imm ? dec.fld : ram_rdata;

   add_exec_adder u_adder (
      .lhs(working_reg_alias),
      .rhs(add_rhs),
      .res(add_out)
   );

   // Bus handshake; accesses stall while an instruction runs
   assign busy = (phase != add_exec_pkg::ST_IDLE);
   assign pready = psel && penable && wait_done && !busy;
   assign bus_write = pready && pwrite;
   assign pslverr = pready && !hit;

   // Memory port is shared: execution owns it while busy
   always_comb begin
      ram_addr = busy ? eff_addr : mem_addr;
      ram_wdata = busy ? result.sum : pwdata[7:0];
      ram_we = (bus_write && paddr == `OFS_MEM_DATA) ||
         (phase == add_exec_pkg::ST_WRITE && !illegal && dec.is_reg && dec.to_file); // [RL4]
   end

   add_exec_ram u_ram (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .addr(ram_addr),
      .we(ram_we),
      .wdata(ram_wdata),
      .rdata(ram_rdata)
   );

   // Register read view
   always_comb begin
      hit = 1'b1;
      read_mux = 32'h0000_0000;
      case (paddr)
         `OFS_INSTR: read_mux = {16'h0000, instr};
         `OFS_WORK: read_mux = {24'h00_0000, working_reg_alias};
         `OFS_BANK: read_mux = {28'h000_0000, bank_select_register};
         `OFS_INDEX: read_mux = {20'h0_0000, index_base};
         `OFS_CTRL: read_mux = {31'h0000_0000, ext_enable};
         `OFS_FLAGS: read_mux = {27'h000_0000, flags};
         `OFS_STATE: read_mux = {30'h0000_0000, illegal, busy};
         `OFS_MEM_ADDR: read_mux = {20'h0_0000, mem_addr};
         `OFS_MEM_DATA: read_mux = {24'h00_0000, ram_rdata};
         default: hit = 1'b0;
      endcase
   end

   // Bus side next values
   always_comb begin
      // A stalled access restarts its wait once idle, so read data are taken after execution
      next_wait_done = psel && penable && !pready && !busy;
      next_prdata = next_wait_done ? read_mux : prdata;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_done <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         wait_done <= next_wait_done;
         prdata <= next_prdata;
      end
   end

   // Sequencer and architectural registers
   always_comb begin
      next_phase = phase;
      next_instr = instr;
      next_working = working_reg_alias;
      next_bank = bank_select_register;
      next_index = index_base;
      next_ext = ext_enable;
      next_flags = flags;
      next_illegal = illegal;
      next_mem_addr = mem_addr;
      next_result = result;
      if (bus_write) begin
         case (paddr)
            `OFS_WORK: next_working = pwdata[7:0];
            `OFS_BANK: next_bank = pwdata[3:0];
            `OFS_INDEX: next_index = pwdata[11:0];
            `OFS_CTRL: next_ext = pwdata[0];
            `OFS_FLAGS: next_flags = pwdata[4:0];
            `OFS_MEM_ADDR: next_mem_addr = pwdata[11:0];
            default: next_ext = ext_enable;
         endcase
      end
      case (phase)
         add_exec_pkg::ST_IDLE: begin
            if (bus_write && paddr == `OFS_INSTR) begin
               next_instr = pwdata[15:0];
               next_phase = add_exec_pkg::ST_DECODE; // [RL9]
            end
         end
         add_exec_pkg::ST_DECODE: begin
            next_illegal = !(dec.is_imm || dec.is_reg);
            next_phase = add_exec_pkg::ST_READ; // [RL9]
         end
         add_exec_pkg::ST_READ: begin
            next_phase = add_exec_pkg::ST_PROC; // [RL9]
         end
         add_exec_pkg::ST_PROC: begin
            next_result = add_out;
            next_phase = add_exec_pkg::ST_WRITE; // [RL9]
         end
         add_exec_pkg::ST_WRITE: begin
            if (!illegal) begin
               next_flags = {result.neg, result.overflow_flag, result.zero,
                  result.digit_carry_flag, result.carry}; // [RL8]
               if (dec.is_imm || !dec.to_file) begin
                  next_working = result.sum; // [RL1] [RL3]
               end
            end
            next_phase = add_exec_pkg::ST_IDLE; // [RL9]
         end
         default: next_phase = add_exec_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase <= add_exec_pkg::ST_IDLE;
         instr <= `RST_INSTR;
         working_reg_alias <= `RST_WORK;
         bank_select_register <= `RST_BANK;
         index_base <= `RST_INDEX;
         ext_enable <= 1'b0;
         flags <= `RST_FLAGS;
         illegal <= 1'b0;
         mem_addr <= `RST_MEM_ADDR;
         result <= '0;
      end else begin
         phase <= next_phase;
         instr <= next_instr;
         working_reg_alias <= next_working;
         bank_select_register <= next_bank;
         index_base <= next_index;
         ext_enable <= next_ext;
         flags <= next_flags;
         illegal <= next_illegal;
         mem_addr <= next_mem_addr;
         result <= next_result;
      end
   end

   // Reference sum for flag checks
   logic [8:0] check_sum;
   logic carry_ref;
   logic zero_ref;
   logic neg_ref;
   assign check_sum = {1'b0, working_reg_alias} + {1'b0, add_rhs};
   assign carry_ref = check_sum[8];
   assign zero_ref = (check_sum[7:0] == 8'h00);
   assign neg_ref = check_sum[7];
   logic [4:0] nib_sum;
   logic dc_ref;
   logic ov_ref;
   assign nib_sum = {1'b0, working_reg_alias[3:0]} + {1'b0, add_rhs[3:0]};
   assign dc_ref = nib_sum[4];
   assign ov_ref = (working_reg_alias[7] == add_rhs[7]) &&
      (check_sum[7] != working_reg_alias[7]);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   chk_phase_order: assert property ( // [RL9]
      phase == add_exec_pkg::ST_DECODE |=> phase == add_exec_pkg::ST_READ
         ##1 phase == add_exec_pkg::ST_PROC ##1 phase == add_exec_pkg::ST_WRITE
         ##1 phase == add_exec_pkg::ST_IDLE)
      else $error("phase order broken");

   chk_imm_sum: assert property ( // [RL1]
      (phase == add_exec_pkg::ST_PROC && instr[15:8] == 8'h0F) |=> ##1
         working_reg_alias == 8'($past(working_reg_alias, 2) + instr[7:0]))
      else $error("immediate sum not in working register");

   chk_reg_operand: assert property ( // [RL2]
      (phase == add_exec_pkg::ST_PROC && instr[15:10] == 6'h09) |=>
         result.sum == 8'(working_reg_alias + $past(ram_rdata)))
      else $error("register operand sum wrong");

   chk_dest_working: assert property ( // [RL3]
      (phase == add_exec_pkg::ST_WRITE && dec.is_reg && !instr[9]) |->
         !ram_we ##1 working_reg_alias == $past(result.sum))
      else $error("working destination not honoured");

   chk_dest_file: assert property ( // [RL4]
      (phase == add_exec_pkg::ST_WRITE && dec.is_reg && instr[9]) |->
         ram_we && ram_addr == eff_addr && ram_wdata == result.sum
         ##1 $stable(working_reg_alias))
      else $error("file destination not honoured");

   chk_access_bank: assert property ( // [RL5]
      (phase == add_exec_pkg::ST_READ && !instr[8] &&
         !(ext_enable && instr[7:0] <= 8'h5F)) |->
         ram_addr == {(instr[7:0] >= 8'h60) ? 4'hF : 4'h0, instr[7:0]})
      else $error("access bank address wrong");

   chk_banked_addr: assert property ( // [RL6]
      (phase == add_exec_pkg::ST_READ && instr[8]) |->
         ram_addr == {bank_select_register, instr[7:0]})
      else $error("banked address wrong");

   chk_indexed_addr: assert property ( // [RL7]
      (phase == add_exec_pkg::ST_READ && ext_enable && !instr[8] &&
         instr[7:0] <= 8'h5F) |-> ram_addr == 12'(index_base + {4'h0, instr[7:0]}))
      else $error("indexed offset address wrong");

   chk_flag_update: assert property ( // [RL8]
      (phase == add_exec_pkg::ST_PROC && !illegal) |=> ##1
         flags[`FLG_C] == $past(carry_ref, 2) && flags[`FLG_Z] == $past(zero_ref, 2)
         && flags[`FLG_N] == $past(neg_ref, 2))
      else $error("status flags not updated from sum");

   chk_flag_carries: assert property ( // [RL8]
      (phase == add_exec_pkg::ST_PROC && !illegal) |=> ##1
         flags[`FLG_DIGIT_CARRY] == $past(dc_ref, 2)
         && flags[`FLG_OVERFLOW] == $past(ov_ref, 2))
      else $error("digit carry or overflow flag wrong");

   chk_illegal_keep: assert property ( // [RL8]
      (phase == add_exec_pkg::ST_WRITE && illegal) |=>
         flags == $past(flags) && working_reg_alias == $past(working_reg_alias))
      else $error("illegal word changed flags or working register");

   chk_state_fresh: assert property ( // [RL9]
      (pready && !pwrite && paddr == `OFS_STATE) |-> prdata[0] == 1'b0)
      else $error("state read returned a busy snapshot");

   chk_work_fresh: assert property ( // [RL9]
      (pready && !pwrite && paddr == `OFS_WORK) |-> prdata[7:0] == working_reg_alias)
      else $error("working register read is stale");

endmodule

// File: test/add_instruction_execute_tb.sv
// Self-checking bench for the addition execute unit, driven over APB.
// Assumes the unit's constants header is on the include path.
`timescale 1ns/10ps
`include "add_exec_cfg.svh"
module add_instruction_execute_tb;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] rq;
   logic rerr;
   logic rdy;
   int wait_n;
   int bad_count = 0;
   int checked = 0;

   add_exec_core i_add_exec_core (
      .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   initial begin
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One transfer; ready, data and error are taken at the rising edge that ends it
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      wait_n = 0;
      rdy = 1'b0;
      @(posedge ref_clk);
      penable <= 1'b1;
      while (!rdy && wait_n < 50) begin
         @(posedge ref_clk);
         rdy = pready;
         rq = prdata;
         rerr = pslverr;
         wait_n++;
      end
      if (!rdy) bad_count++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rq, exp);
   endtask

   task automatic mem_wr(input logic [11:0] a, input logic [7:0] v);
      wr(`OFS_MEM_ADDR, {20'h0_0000, a});
      wr(`OFS_MEM_DATA, {24'h00_0000, v});
   endtask

   task automatic mem_chk(input logic [11:0] a, input logic [7:0] v);
      wr(`OFS_MEM_ADDR, {20'h0_0000, a});
      rd_chk(`OFS_MEM_DATA, {24'h00_0000, v});
   endtask

   task automatic run(input logic [7:0] w, input logic [15:0] word);
      wr(`OFS_WORK, {24'h00_0000, w});
      wr(`OFS_INSTR, {16'h0000, word});
   endtask

   task automatic t_imm;
      run(8'h10, 16'h0F15);
      rd_chk(`OFS_STATE, 32'h0000_0000);
      chk(wait_n, 4);
      rd_chk(`OFS_WORK, 32'h0000_0025);
      rd_chk(`OFS_FLAGS, 32'h0000_0000);
      run(8'h0F, 16'h0F01);
      rd_chk(`OFS_FLAGS, 32'h0000_0002);
      run(8'h7F, 16'h0F01);
      rd_chk(`OFS_FLAGS, 32'h0000_001A);
      $display("test add literal done");
   endtask

   task automatic t_reg;
      wr(`OFS_BANK, 32'h0000_0002);
      mem_wr(12'h250, 8'hC2);
      mem_wr(12'h050, 8'h01);
      run(8'hD9, 16'h2550);
      rd_chk(`OFS_WORK, 32'h0000_009B);
      rd_chk(`OFS_FLAGS, 32'h0000_0011);
      mem_chk(12'h250, 8'hC2);
      mem_wr(12'hF70, 8'h80);
      mem_wr(12'h270, 8'h11);
      run(8'h80, 16'h2670);
      mem_chk(12'hF70, 8'h00);
      mem_chk(12'h270, 8'h11);
      rd_chk(`OFS_WORK, 32'h0000_0080);
      rd_chk(`OFS_FLAGS, 32'h0000_000D);
      mem_wr(12'h010, 8'h05);
      run(8'h80, 16'h2610);
      mem_chk(12'h010, 8'h85);
      $display("test add memory done");
   endtask

   task automatic t_index;
      wr(`OFS_CTRL, 32'h0000_0001);
      wr(`OFS_INDEX, 32'h0000_0123);
      mem_wr(12'h182, 8'h03);
      mem_wr(12'h05F, 8'h40);
      run(8'h01, 16'h265F);
      mem_chk(12'h182, 8'h04);
      mem_chk(12'h05F, 8'h40);
      mem_wr(12'hF60, 8'h07);
      run(8'h01, 16'h2660);
      mem_chk(12'hF60, 8'h08);
      $display("test indexed offset done");
   endtask

   task automatic t_bus;
      rd_chk(`OFS_WORK, 32'h0000_0000);
      rd_chk(`OFS_FLAGS, 32'h0000_0000);
      rd_chk(8'h24, 32'h0000_0000);
      chk(rerr, 1'b1);
      run(8'h33, 16'h0E00);
      rd_chk(`OFS_STATE, 32'h0000_0002);
      rd_chk(`OFS_WORK, 32'h0000_0033);
      rd_chk(`OFS_FLAGS, 32'h0000_0000);
      $display("test bus and illegal word done");
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #1000000;
      bad_count++;
      final_report();
   end

   initial begin
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      t_bus();
      t_imm();
      t_reg();
      t_index();
      final_report();
   end
endmodule
